/* File: capch_pkg.sv */
// Constants and types of the raw and stream capture channel
// What this block does
// - Stop size is vertical:horizontal, 24 bits
// - Raw mode: DMA event at threshold count
// - Mode field x1x selects raw capture
// - Start on global and channel enable
// - Count equals stop sets complete, interrupt
// - Continuous restarts on next enabled edge
// - Noncontinuous stops unless flag cleared meanwhile
// - Single frame waits for flag clear
// - Overrun sets status, interrupts if enabled
// - Block write flushes FIFO, stops events
// - Blocked samples dropped, counter keeps counting
// - Raw unblock resumes after sync period
// - Stream mode: DMA event at threshold count, as in raw mode
// - Eight timestamp bytes follow each packet that is not discarded
// - Stream input mode: parallel or serial
// - Time counter compare under mask interrupts
// - Periodic interrupt every ticks cycles
// - Stream needs select bit, mode 010
// - Stream starts on enable plus packet start
// - Stream unblock acts at packet start
// - Frame complete flag is write-1-clear
// - Position fields read the sample counter
`default_nettype none
package capch_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 20;
  localparam int CNT_W  = 24;
  localparam int STOP_W = 12;
  localparam logic [5:0] A_PCTL = 6'h00;
  localparam logic [5:0] A_PIE  = 6'h04;
  localparam logic [5:0] A_PIS  = 6'h08;
  localparam logic [5:0] A_CCTL = 6'h0C;
  localparam logic [5:0] A_STAT = 6'h10;
  localparam logic [5:0] A_STOP = 6'h14;
  localparam logic [5:0] A_THR  = 6'h18;
  localparam logic [5:0] A_TSC  = 6'h1C;
  localparam logic [5:0] A_CMPL = 6'h20;
  localparam logic [5:0] A_CMPH = 6'h24;
  localparam logic [5:0] A_MSKL = 6'h28;
  localparam logic [5:0] A_MSKH = 6'h2C;
  localparam logic [5:0] A_TICK = 6'h30;
  localparam logic [5:0] A_STCL = 6'h34;
  localparam logic [5:0] A_STCH = 6'h38;
  localparam int PC_GCAP = 0;
  localparam int PC_TSEL = 1;
  localparam int CC_MODE = 0;
  localparam int CC_CONT = 3;
  localparam int CC_FRM  = 4;
  localparam int CC_PACK = 5;
  localparam int CC_RDS  = 7;
  localparam int CC_BLK  = 8;
  localparam int CC_EN   = 9;
  localparam int ST_FRAME_COMPLETE_FLAG = 30;
  localparam int SP_VERT = 16;
  localparam int IS_OVR  = 0;
  localparam int IS_CMP  = 1;
  localparam int IS_STCM = 2;
  localparam int IS_TICK = 3;
  localparam int SC_SER  = 0;
  localparam int SC_ERRF = 1;
  localparam int ERR_BIT = 8;
  localparam logic [9:0]  CCTL_RST = 10'h000;
  localparam logic [23:0] STOP_RST = 24'h000000;
  localparam logic [23:0] THR_RST  = 24'h000000;
  localparam logic [31:0] WORD_RST = 32'h00000000;
  localparam logic [2:0]  MODE_TS  = 3'h2;
  localparam logic [3:0]  TS_BYTES = 4'h8;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_CAP  = 2'b10,
    S_HOLD = 2'b11
  } capch_state_t;
endpackage
`default_nettype wire

/* File: capch_pin_if.sv */
// Synchronised link pins handed from the pin stage to the channel core
`default_nettype none
interface capch_pin_if;
  import capch_pkg::*;
  logic              clk_rise;
  logic              en;
  logic              pkt;
  logic [DATA_W-1:0] data;
  modport sync (output clk_rise, output en, output pkt, output data);
  modport core (input clk_rise, input en, input pkt, input data);
endinterface
`default_nettype wire

/* File: capch_pin_sync.sv */
// Two-flop synchroniser and capture clock edge finder for the link pins
`default_nettype none
module capch_pin_sync (
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_pin,
  input  wire logic                          en_pin,
  input  wire logic                          pkt_pin,
  input  wire logic [capch_pkg::DATA_W-1:0]  data_pin,
  capch_pin_if.sync                          pins
);
  import capch_pkg::*;
  logic [2:0]        clk_s_q;
  logic              en_s1_q;
  logic              pkt_s1_q;
  logic [DATA_W-1:0] data_s1_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clk_s_q   <= 3'h0;
      en_s1_q   <= 1'b0;
      pkt_s1_q  <= 1'b0;
      data_s1_q <= '0;
      pins.en   <= 1'b0;
      pins.pkt  <= 1'b0;
      pins.data <= '0;
    end else begin
      clk_s_q   <= {clk_s_q[1:0], clk_pin};
      en_s1_q   <= en_pin;
      pkt_s1_q  <= pkt_pin;
      data_s1_q <= data_pin;
      pins.en   <= en_s1_q;
      pins.pkt  <= pkt_s1_q;
      pins.data <= data_s1_q;
    end
  end

  // Edge seen after the second flop only; first stage feeds nothing else
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pins.clk_rise <= 1'b0;
    end else begin
      pins.clk_rise <= clk_s_q[1] & ~clk_s_q[2];
    end
  end
endmodule // capch_pin_sync
`default_nettype wire

/* File: capch_top.sv */
// Raw data and transport stream capture channel core with register port
`default_nettype none
module capch_top #(
  parameter bit CHANNEL_A = 1'b1
) (
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  input  wire logic                          capture_clock_in,
  input  wire logic                          capture_enable_in,
  input  wire logic                          packet_start_in,
  input  wire logic [capch_pkg::DATA_W-1:0]  pin_data,
  input  wire logic                          fifo_overrun,
  input  wire logic [capch_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [31:0]                   reg_rdata,
  output logic                               luma_dma_event,
  output logic                               fifo_flush,
  output logic                               sample_valid,
  output logic      [capch_pkg::DATA_W-1:0]  sample_data,
  output logic                               irq
);
  import capch_pkg::*;

  capch_pin_if pin_if ();

  capch_pin_sync u_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .clk_pin  (capture_clock_in),
    .en_pin   (capture_enable_in),
    .pkt_pin  (packet_start_in),
    .data_pin (pin_data),
    .pins     (pin_if.sync)
  );

  logic [1:0]        pctl_q;
  logic [3:0]        pie_q;
  logic [3:0]        pis_q;
  logic [9:0]        cctl_q;
  logic [CNT_W-1:0]  stop_q;
  logic [CNT_W-1:0]  thr_q;
  logic [1:0]        tsc_q;
  logic [63:0]       cmp_q;
  logic [63:0]       msk_q;
  logic [31:0]       ticks_q;
  logic [31:0]       rdata_q;
  logic              frame_complete_flag_q;
  capch_state_t      state_q;
  capch_state_t      state_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  thr_cnt_q;
  logic [2:0]        bit_cnt_q;
  logic [7:0]        byte_q;
  logic              need_sync_q;
  logic              sync_seen_q;
  logic              dma_blk_q;
  logic              err_pkt_q;
  logic              blk_prev_q;
  logic [3:0]        ts_cnt_q;
  logic [63:0]       ts_snap_q;
  logic [63:0]       stc_q;
  logic              hit_prev_q;
  logic [31:0]       tick_cnt_q;
  logic              evt_q;
  logic              flush_q;
  logic              sval_q;
  logic [DATA_W-1:0] sdata_q;
  logic              irq_q;

  logic wr_pctl, wr_pie, wr_pis, wr_cctl, wr_stat, wr_stop, wr_thr;
  logic wr_tsc, wr_cmpl, wr_cmph, wr_mskl, wr_mskh, wr_tick;
  assign wr_pctl = reg_wr && (reg_addr == A_PCTL);
  assign wr_pie  = reg_wr && (reg_addr == A_PIE);
  assign wr_pis  = reg_wr && (reg_addr == A_PIS);
  assign wr_cctl = reg_wr && (reg_addr == A_CCTL);
  assign wr_stat = reg_wr && (reg_addr == A_STAT);
  assign wr_stop = reg_wr && (reg_addr == A_STOP);
  assign wr_thr  = reg_wr && (reg_addr == A_THR);
  assign wr_tsc  = reg_wr && (reg_addr == A_TSC);
  assign wr_cmpl = reg_wr && (reg_addr == A_CMPL);
  assign wr_cmph = reg_wr && (reg_addr == A_CMPH);
  assign wr_mskl = reg_wr && (reg_addr == A_MSKL);
  assign wr_mskh = reg_wr && (reg_addr == A_MSKH);
  assign wr_tick = reg_wr && (reg_addr == A_TICK);

  logic [2:0] mode;
  logic ts_mode, run_en, blk, cont, frm, ts_ser, cap_edge, start_ok;
  logic take, unit, done, discard, stc_hit, tick_hit, thr_hit, first, err_new;
  logic [CNT_W-1:0] cnt_inc;
  logic [CNT_W-1:0] thr_inc;
  assign mode     = cctl_q[CC_MODE +: 3];
  assign ts_mode  = CHANNEL_A && pctl_q[PC_TSEL] && (mode == MODE_TS);
  assign run_en   = pctl_q[PC_GCAP] && cctl_q[CC_EN] && mode[1];
  assign blk      = cctl_q[CC_BLK];
  assign cont     = cctl_q[CC_CONT];
  assign frm      = cctl_q[CC_FRM];
  assign ts_ser   = ts_mode && tsc_q[SC_SER];
  assign cap_edge = pin_if.clk_rise;
  // Raw start may wait for a quiet enable period; stream needs packet start
  assign start_ok = ts_mode ? (pin_if.en && pin_if.pkt)
                  : (pin_if.en && (!need_sync_q || sync_seen_q));
  assign take = run_en && cap_edge && pin_if.en &&
                (((state_q == S_WAIT) && start_ok) || (state_q == S_CAP));
  assign unit    = take && (!ts_ser || ((state_q == S_CAP) && (bit_cnt_q == 3'h7)));
  assign cnt_inc = ((state_q == S_WAIT) ? '0 : cnt_q) + 24'h000001;
  assign done    = unit && (cnt_inc == stop_q);
  // First sample of a frame is judged by its own start, not the last frame's marks
  assign first   = take && (state_q == S_WAIT);
  assign err_new = ts_mode && tsc_q[SC_ERRF] && pin_if.data[ERR_BIT];
  assign discard = blk || (first ? err_new : (dma_blk_q || err_pkt_q));
  assign thr_inc = ((state_q == S_WAIT) ? '0 : thr_cnt_q) + 24'h000001;
  assign thr_hit = unit && (thr_inc == thr_q);
  assign stc_hit = (((stc_q ^ cmp_q) & msk_q) == 64'h0) && !hit_prev_q;
  assign tick_hit = (ticks_q != 32'h0) && ((tick_cnt_q + 32'h1) >= ticks_q);

  // Register writes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pctl_q  <= 2'h0;
      pie_q   <= 4'h0;
      cctl_q  <= CCTL_RST;
      stop_q  <= STOP_RST;
      thr_q   <= THR_RST;
      tsc_q   <= 2'h0;
      cmp_q   <= {WORD_RST, WORD_RST};
      msk_q   <= {WORD_RST, WORD_RST};
      ticks_q <= WORD_RST;
    end else begin
      if (wr_pctl) pctl_q <= reg_wdata[1:0];
      if (wr_pie) pie_q <= reg_wdata[3:0];
      if (wr_cctl) cctl_q <= reg_wdata[9:0];
      if (wr_stop) stop_q <= {reg_wdata[SP_VERT +: STOP_W], reg_wdata[STOP_W-1:0]};
      if (wr_thr) thr_q <= reg_wdata[CNT_W-1:0];
      if (wr_tsc) tsc_q <= reg_wdata[1:0];
      if (wr_cmpl) cmp_q[31:0] <= reg_wdata;
      if (wr_cmph) cmp_q[63:32] <= reg_wdata;
      if (wr_mskl) msk_q[31:0] <= reg_wdata;
      if (wr_mskh) msk_q[63:32] <= reg_wdata;
      if (wr_tick) ticks_q <= reg_wdata;
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= WORD_RST;
    end else if (!reg_rd) begin
      rdata_q <= WORD_RST;
    end else begin
      case (reg_addr)
        A_PCTL:  rdata_q <= {30'h0, pctl_q};
        A_PIE:   rdata_q <= {28'h0, pie_q};
        A_PIS:   rdata_q <= {28'h0, pis_q};
        A_CCTL:  rdata_q <= {22'h0, cctl_q};
        A_STAT:  rdata_q <= {1'b0, frame_complete_flag_q, 4'h0, state_q, cnt_q};
        A_STOP:  rdata_q <= {4'h0, stop_q[23:12], 4'h0, stop_q[11:0]};
        A_THR:   rdata_q <= {8'h0, thr_q};
        A_TSC:   rdata_q <= {30'h0, tsc_q};
        A_CMPL:  rdata_q <= cmp_q[31:0];
        A_CMPH:  rdata_q <= cmp_q[63:32];
        A_MSKL:  rdata_q <= msk_q[31:0];
        A_MSKH:  rdata_q <= msk_q[63:32];
        A_TICK:  rdata_q <= ticks_q;
        A_STCL:  rdata_q <= stc_q[31:0];
        A_STCH:  rdata_q <= stc_q[63:32];
        default: rdata_q <= WORD_RST;
      endcase
    end
  end

  // Capture sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: if (run_en) state_d = S_WAIT;
      S_WAIT: if (take) state_d = S_CAP;
      S_CAP:  state_d = S_CAP;
      S_HOLD: if (!cont && !frm && !frame_complete_flag_q) state_d = S_WAIT;
      default: state_d = S_IDLE;
    endcase
    if (done) begin
      if (cont) state_d = S_WAIT;
      else if (frm) state_d = frame_complete_flag_q ? S_HOLD : S_WAIT;
      else state_d = S_HOLD;
    end
    if (!run_en) state_d = S_IDLE;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) state_q <= S_IDLE;
    else state_q <= state_d;
  end

  // Sample and byte counting keeps running while blocked
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q     <= '0;
      thr_cnt_q <= '0;
      bit_cnt_q <= 3'h0;
      byte_q    <= 8'h0;
    end else if (take) begin
      bit_cnt_q <= (state_q == S_WAIT) ? 3'h1 : bit_cnt_q + 3'h1;
      byte_q    <= {byte_q[6:0], pin_if.data[0]};
      if (unit) begin
        cnt_q     <= cnt_inc;
        thr_cnt_q <= thr_hit ? '0 : thr_inc;
      end else if (state_q == S_WAIT) begin
        cnt_q     <= '0;
        thr_cnt_q <= '0;
      end
    end
  end

  // Sync period is a capture edge with enable low
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      need_sync_q <= 1'b0;
      sync_seen_q <= 1'b0;
      blk_prev_q  <= 1'b0;
    end else begin
      blk_prev_q <= blk;
      if ((state_q == S_IDLE && state_d == S_WAIT && cctl_q[CC_RDS]) ||
          (state_q == S_HOLD && state_d == S_WAIT && cctl_q[CC_RDS]) ||
          (blk_prev_q && !blk && !ts_mode)) begin
        need_sync_q <= 1'b1;
        sync_seen_q <= 1'b0;
      end else if (take && state_q == S_WAIT) begin
        need_sync_q <= 1'b0;
        sync_seen_q <= 1'b0;
      end else if (need_sync_q && cap_edge && !pin_if.en) begin
        sync_seen_q <= 1'b1;
      end
    end
  end

  // Events stay blocked until the next block or packet start
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dma_blk_q <= 1'b0;
      err_pkt_q <= 1'b0;
    end else begin
      if (blk) dma_blk_q <= 1'b1;
      else if (take && state_q == S_WAIT) dma_blk_q <= 1'b0;
      if (take && state_q == S_WAIT)
        err_pkt_q <= ts_mode && tsc_q[SC_ERRF] && pin_if.data[ERR_BIT];
    end
  end

  // Timestamp bytes go out behind the packet, before the next one
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ts_cnt_q  <= 4'h0;
      ts_snap_q <= 64'h0;
    end else if (done && ts_mode && !discard) begin
      ts_cnt_q  <= TS_BYTES;
      ts_snap_q <= stc_q;
    end else if (ts_cnt_q != 4'h0) begin
      ts_cnt_q  <= ts_cnt_q - 4'h1;
      ts_snap_q <= {8'h0, ts_snap_q[63:8]};
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sval_q  <= 1'b0;
      sdata_q <= '0;
      evt_q   <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      evt_q   <= thr_hit && !discard;
      flush_q <= wr_cctl && reg_wdata[CC_BLK];
      if (ts_cnt_q != 4'h0) begin
        sval_q  <= 1'b1;
        sdata_q <= {12'h0, ts_snap_q[7:0]};
      end else begin
        sval_q  <= unit && !discard;
        sdata_q <= ts_mode ? {12'h0, ts_ser ? {byte_q[6:0], pin_if.data[0]}
                                            : pin_if.data[7:0]}
                           : pin_if.data;
      end
    end
  end

  // Frame complete: set beats a simultaneous write-1 clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) frame_complete_flag_q <= 1'b0;
    else if (done) frame_complete_flag_q <= 1'b1;
    else if (wr_stat && reg_wdata[ST_FRAME_COMPLETE_FLAG]) frame_complete_flag_q <= 1'b0;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stc_q      <= 64'h0;
      hit_prev_q <= 1'b1; // No compare hit merely for leaving reset
      tick_cnt_q <= 32'h0;
    end else begin
      stc_q      <= stc_q + 64'h1;
      hit_prev_q <= ((stc_q ^ cmp_q) & msk_q) == 64'h0;
      tick_cnt_q <= tick_hit ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pis_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      pis_q <= (pis_q & ~(wr_pis ? reg_wdata[3:0] : 4'h0)) |
               {tick_hit, stc_hit, done, fifo_overrun};
      irq_q <= (pis_q & pie_q) != 4'h0;
    end
  end

  assign reg_rdata      = rdata_q;
  assign luma_dma_event = evt_q;
  assign fifo_flush     = flush_q;
  assign sample_valid   = sval_q;
  assign sample_data    = sdata_q;
  assign irq            = irq_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_frame_done: assert property (done |=> frame_complete_flag_q && pis_q[IS_CMP])
    else $error("completion not flagged");
  a_flag_w1c: assert property (wr_stat && reg_wdata[ST_FRAME_COMPLETE_FLAG] && !done |=> !frame_complete_flag_q)
    else $error("frame flag not cleared");
  a_flag_w0: assert property (frame_complete_flag_q && !(wr_stat && reg_wdata[ST_FRAME_COMPLETE_FLAG]) |=> frame_complete_flag_q)
    else $error("frame flag lost");
  a_thr_event: assert property (thr_hit && !discard |=> luma_dma_event)
    else $error("missing dma event");
  a_blk_noevt: assert property (blk |=> !luma_dma_event)
    else $error("event while blocked");
  a_blk_count: assert property (unit && blk && state_q == S_CAP
    |=> !sample_valid || ts_cnt_q != 4'h0 ##0 cnt_q == $past(cnt_q) + 24'h1)
    else $error("blocked count wrong");
  a_ovr_irq: assert property (fifo_overrun && pie_q[IS_OVR] |=> ##1 irq)
    else $error("overrun irq missing");
  a_cont_wait: assert property (done && cont && run_en |=> state_q == S_WAIT)
    else $error("no continuous restart");
  a_noncont_stop: assert property (done && !cont && frm && frame_complete_flag_q && run_en
    |=> state_q == S_HOLD)
    else $error("noncontinuous not stopped");
  a_single_hold: assert property (state_q == S_HOLD && !cont && !frm && frame_complete_flag_q
    && run_en |=> state_q == S_HOLD)
    else $error("single frame resumed");
  a_ts_stamp: assert property (done && ts_mode && !discard |=> ##1 sample_valid[*8])
    else $error("timestamp bytes missing");
  a_ts_start: assert property (state_q == S_WAIT && ts_mode && !pin_if.pkt && run_en
    |=> state_q != S_CAP)
    else $error("stream start without packet");
  a_stc_irq: assert property (stc_hit |=> pis_q[IS_STCM])
    else $error("compare status missing");

  c_block_done: cover property (done && !ts_mode);
  c_packet_done: cover property (done && ts_mode);
  c_dma_event: cover property (luma_dma_event);
  c_hold: cover property (state_q == S_HOLD);
endmodule // capch_top
`default_nettype wire

/* File: capch_src.sv */
// Link source model: raw or stream frames on the capture pins
`default_nettype none
module capch_src (
  output logic        cclk,
  output logic        cen,
  output logic        pstart,
  output logic [19:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] val;
  initial begin
    cclk   = 1'b0;
    cen    = 1'b0;
    pstart = 1'b0;
    data   = 20'hA5A5A;
    val    = 20'h00010;
  end
  // Clock stands still between frames; one low-enable edge ends each frame
  task automatic frame(input int n, input bit pkt);
    for (int i = 0; i <= n; i++) begin
      #57;
      cen    = (i < n);
      pstart = pkt && (i == 0);
      data   = (i < n) ? val : ~data;
      val    = val + 20'h00001;
      #43 cclk = 1'b1;
      #100 cclk = 1'b0;
    end
    #50;
    cen    = 1'b0;
    pstart = 1'b0;
    data   = ~data; // Released lines toggle, not hold
  endtask
endmodule // capch_src
`default_nettype wire

/* File: capch_tb.sv */
// Self-checking bench of the capture channel
`default_nettype none
module capch_tb;
  import capch_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, sys_rst, cclk, cen, pstart, fifo_overrun, reg_wr, reg_rd;
  logic luma_dma_event, fifo_flush, sample_valid, irq;
  logic [19:0] pin_data, sample_data, last_sd;
  logic [5:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  int failures, tests_run, sv_n, ev_n, fl_n, cyc, n, seed;
  logic [2:0] mode_tab [4] = '{3'h2, 3'h3, 3'h6, 3'h7};
  capch_src i_src (.cclk(cclk), .cen(cen), .pstart(pstart), .data(pin_data));
  capch_top i_dut (
    .clock(clock), .sys_rst(sys_rst), .capture_clock_in(cclk),
    .capture_enable_in(cen), .packet_start_in(pstart), .pin_data(pin_data),
    .fifo_overrun(fifo_overrun), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .luma_dma_event(luma_dma_event), .fifo_flush(fifo_flush),
    .sample_valid(sample_valid), .sample_data(sample_data), .irq(irq)
  );
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (sample_valid === 1'b1) sv_n++;
    if (sample_valid === 1'b1) last_sd = sample_data;
    if (luma_dma_event === 1'b1) ev_n++;
    if (fifo_flush === 1'b1) fl_n++;
    if (cyc == 80000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [5:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    sv_n = 0;
    ev_n = 0;
    fl_n = 0;
  endtask
  // Samples forwarded for k frames of n under the chosen operation
  function automatic int exp_samples(input bit cont, input bit frm, input int k, input int n);
    if (cont) return k * n;
    if (frm) return (k < 2 ? k : 2) * n;
    return n;
  endfunction
  task automatic raw_run(input logic [2:0] mode, input bit cont, input bit frm);
    int e;
    // Multiples of eight keep 8-bit transfers an even number of words
    n = 8 << ($unsigned($random(seed)) % 2);
    do_reset();
    wr(A_PCTL, 32'h00000001);
    wr(A_PIE, 32'h00000002);
    wr(A_STOP, {20'h00000, n[11:0]});
    wr(A_THR, n);
    wr(A_CCTL, {22'h0, 1'b1, 4'h0, frm, cont, mode});
    repeat (3) begin
      i_src.frame(n, 1'b0);
      repeat (20) @(posedge clock);
    end
    e = exp_samples(cont, frm, 3, n);
    chk(sv_n, e);
    chk(ev_n, e / n);
    if (cont) chk(last_sd, i_src.val - 20'h00002);
    rdr(A_STAT);
    chk(rd[ST_FRAME_COMPLETE_FLAG], 1'b1);
    rdr(A_PIS);
    chk(rd[IS_CMP], 1'b1);
    chk(irq, 1'b1);
    wr(A_STAT, 32'h00000000);
    rdr(A_STAT);
    chk(rd[ST_FRAME_COMPLETE_FLAG], 1'b1);
    wr(A_STAT, 32'h40000000);
    rdr(A_STAT);
    chk(rd[ST_FRAME_COMPLETE_FLAG], 1'b0);
    if (!cont && !frm) begin
      i_src.frame(n, 1'b0);
      repeat (20) @(posedge clock);
      chk(sv_n, 2 * n);
    end
  endtask
  initial begin
    seed = 40;
    sys_rst = 1'b1;
    fifo_overrun = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 32'h00000000;
    foreach (mode_tab[i]) raw_run(mode_tab[i], 1'b1, 1'b0);
    raw_run(3'h2, 1'b0, 1'b1);
    raw_run(3'h6, 1'b0, 1'b0);
    // Single frame with raw sync: every start waits for a quiet enable edge
    do_reset();
    wr(A_PCTL, 32'h00000001);
    wr(A_STOP, 32'h00000003);
    wr(A_CCTL, 32'h00000282);
    for (int f = 0; f < 4; f++) begin
      if (f == 2) wr(A_STAT, 32'h40000000);
      i_src.frame(3, 1'b0);
      repeat (20) @(posedge clock);
      chk(sv_n, 3 * ((f + 1) / 2));
    end
    // Overrun, then block capture over whole three-sample blocks
    do_reset();
    wr(A_PCTL, 32'h00000001);
    wr(A_PIE, 32'h00000001);
    wr(A_STOP, 32'h00000003);
    wr(A_THR, 32'h00000003);
    wr(A_CCTL, 32'h0000020A);
    @(posedge clock);
    fifo_overrun <= 1'b1;
    @(posedge clock);
    fifo_overrun <= 1'b0;
    rdr(A_PIS);
    chk(rd[IS_OVR], 1'b1);
    chk(irq, 1'b1);
    wr(A_CCTL, 32'h0000030A);
    repeat (3) @(posedge clock);
    chk(fl_n, 1);
    i_src.frame(3, 1'b0);
    repeat (20) @(posedge clock);
    chk(sv_n, 0);
    chk(ev_n, 0);
    rdr(A_STAT);
    chk(rd[23:0], 24'h000003);
    wr(A_CCTL, 32'h0000020A);
    i_src.frame(3, 1'b0);
    repeat (20) @(posedge clock);
    sv_n = 0;
    i_src.frame(3, 1'b0);
    repeat (20) @(posedge clock);
    chk(sv_n, 3);
    chk(ev_n, 1);
    chk(last_sd, i_src.val - 20'h00002);
    rdr(6'h3C);
    chk(rd, 32'h00000000);
    // Time counter compare on a masked low byte, then periodic ticks
    do_reset();
    wr(A_CMPL, 32'h00000080);
    wr(A_MSKL, 32'h000000FF);
    rdr(A_PIS);
    chk(rd[3:0], 4'h0);
    repeat (150) @(posedge clock);
    rdr(A_PIS);
    chk(rd[IS_STCM], 1'b1);
    chk(rd[IS_TICK], 1'b0);
    wr(A_TICK, 32'h00000010);
    repeat (20) @(posedge clock);
    rdr(A_PIS);
    chk(rd[IS_TICK], 1'b1);
    // Eight-byte packets, parallel then serial; with the stamp, four DMA words
    for (int s = 0; s < 2; s++) begin
      do_reset();
      wr(A_PCTL, 32'h00000003);
      wr(A_STOP, 32'h00000008);
      wr(A_THR, 32'h00000008);
      wr(A_TSC, s);
      wr(A_CCTL, {22'h0, 1'b1, 6'h01, MODE_TS});
      i_src.frame(8, 1'b0);
      repeat (20) @(posedge clock);
      chk(sv_n, 0);
      i_src.frame(s ? 64 : 8, 1'b1);
      repeat (30) @(posedge clock);
      chk(sv_n, 8 + 8);
      chk(ev_n, 1);
      chk(last_sd, 20'h00000);
    end
    conclude();
  end
endmodule // capch_tb
`default_nettype wire
